// ---- adcdt_seq_top.sv ----
// Delayed trigger sweep sequencer with AXI4-Lite register slave
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module adcdt_seq_top (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [adcdt_pkg::ADDR_W-1:0]  s_axil_awaddr,
	input  wire logic [2:0]                    s_axil_awprot,
	input  wire logic                          s_axil_awvalid,
	output logic                               s_axil_awready,
	input  wire logic [adcdt_pkg::DATA_W-1:0]  s_axil_wdata,
	input  wire logic [3:0]                    s_axil_wstrb,
	input  wire logic                          s_axil_wvalid,
	output logic                               s_axil_wready,
	output logic [1:0]                         s_axil_bresp,
	output logic                               s_axil_bvalid,
	input  wire logic                          s_axil_bready,
	input  wire logic [adcdt_pkg::ADDR_W-1:0]  s_axil_araddr,
	input  wire logic [2:0]                    s_axil_arprot,
	input  wire logic                          s_axil_arvalid,
	output logic                               s_axil_arready,
	output logic [adcdt_pkg::DATA_W-1:0]       s_axil_rdata,
	output logic [1:0]                         s_axil_rresp,
	output logic                               s_axil_rvalid,
	input  wire logic                          s_axil_rready,
	input  wire logic                          ext_trigger_n,
	input  wire logic                          timer0_underflow,
	input  wire logic                          timer1_underflow,
	input  wire adcdt_pkg::adcdt_fe_rsp_t      fe_rsp,
	output adcdt_pkg::adcdt_fe_cmd_t           fe_cmd,
	output logic                               sweep_done_irq
);
	import adcdt_pkg::*;

	adcdt_cfg_t        cfg;
	adcdt_state_t      state;
	logic              conversion_start_bit;
	logic              early1;
	logic              sweep_done;
	logic [CH_W-1:0]   conv_ch;
	logic              cmd_sample;
	logic [CH_W-1:0]   cmd_sample_ch;
	logic              cmd_convert;
	logic [CH_W-1:0]   cmd_convert_ch;
	logic              ext_fall;
	logic              mode1;
	logic              mode0;
	logic              trig0;
	logic              trig1;
	logic [CH_W-1:0]   last_ch;
	logic              sw_halt;
	logic              start_sweep;
	logic              finish;
	logic              res_we;
	logic [RES_W-1:0]  mem_rdata;
	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data;
	logic [3:0]        w_strb;
	logic              wr_fire;
	logic              wr_low;
	logic              rd_pend;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_word;
	logic              rd_ok;
	logic              wr_ok;

	adcdt_trig_sync u_sync (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ext_trigger_n (ext_trigger_n),
		.trig_fall     (ext_fall)
	);

	adcdt_result_mem u_mem (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (res_we),
		.waddr   (conv_ch),
		.wdata   (fe_rsp.data),
		.raddr   (s_axil_araddr[RES_IDX_LSB +: CH_W]),
		.rdata   (mem_rdata)
	);

	// Trigger source decode
	assign mode1 = cfg.mode2 & cfg.mode3 & ~cfg.trig_sel_a & cfg.trig_sel_b
		& ~cfg.in0_sel & ~cfg.in1_sel;
	assign mode0 = cfg.mode2 & cfg.mode3 & ~cfg.trig_sel_a & ~cfg.trig_sel_b
		& cfg.in0_sel & cfg.in1_sel;
	assign trig0 = (mode1 & ext_fall) | (mode0 & timer0_underflow);
	assign trig1 = (mode1 & ext_fall) | (mode0 & timer1_underflow);

	assign last_ch = {cfg.pin_count, 1'h1};
	assign wr_fire = aw_held & w_held & ~s_axil_bvalid;
	assign wr_low  = wr_fire & w_strb[0];
	assign sw_halt = wr_low & (aw_addr == OFS_CTRL1)
		& ~w_data[C1_START];
	assign start_sweep = (state == st_idle) & trig0;
	assign finish  = (state == st_convn) & fe_rsp.done
		& (conv_ch == last_ch);
	assign res_we  = fe_rsp.done & ~sw_halt
		& ((state == st_conv0) | (state == st_convn));

	// Sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= st_idle;
		end else if (sw_halt) begin
			state <= st_idle;
		end else begin
			unique case (state)
				st_idle: begin
					if (trig0) begin
						state <= st_conv0;
					end
				end
				st_conv0: begin
					if (fe_rsp.done) begin
						state <= (early1 | trig1) ? st_convn : st_wait1;
					end
				end
				st_wait1: begin
					if (trig1) begin
						state <= st_convn;
					end
				end
				st_convn: begin
					// Edges here are deliberately not looked at
					if (finish) begin
						state <= st_idle;
					end
				end
			endcase
		end
	end

	// Second edge seen while input 0 still converts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			early1 <= 1'h0;
		end else if (start_sweep || sw_halt) begin
			early1 <= 1'h0;
		end else if (state == st_conv0 && trig1) begin
			early1 <= 1'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_ch <= CH_FIRST;
		end else if (start_sweep) begin
			conv_ch <= CH_FIRST;
		end else if (state == st_conv0 && fe_rsp.done) begin
			conv_ch <= CH_SECOND;
		end else if (state == st_convn && fe_rsp.done && !finish) begin
			conv_ch <= conv_ch + CH_STEP;
		end
	end

	// Core commands, one-cycle pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_sample     <= 1'h0;
			cmd_sample_ch  <= CH_FIRST;
			cmd_convert    <= 1'h0;
			cmd_convert_ch <= CH_FIRST;
		end else begin
			cmd_sample  <= 1'h0;
			cmd_convert <= 1'h0;
			if (sw_halt) begin
				cmd_sample  <= 1'h0;
			end else if (start_sweep) begin
				cmd_sample     <= 1'h1;
				cmd_sample_ch  <= CH_FIRST;
				cmd_convert    <= 1'h1;
				cmd_convert_ch <= CH_FIRST;
			end else if (state == st_conv0) begin
				if (trig1 && !early1) begin
					cmd_sample    <= 1'h1;
					cmd_sample_ch <= CH_SECOND;
				end
				if (fe_rsp.done && (early1 || trig1)) begin
					cmd_convert    <= 1'h1;
					cmd_convert_ch <= CH_SECOND;
				end
			end else if (state == st_wait1 && trig1) begin
				cmd_sample     <= 1'h1;
				cmd_sample_ch  <= CH_SECOND;
				cmd_convert    <= 1'h1;
				cmd_convert_ch <= CH_SECOND;
			end else if (state == st_convn && fe_rsp.done && !finish) begin
				cmd_sample     <= 1'h1;
				cmd_sample_ch  <= conv_ch + CH_STEP;
				cmd_convert    <= 1'h1;
				cmd_convert_ch <= conv_ch + CH_STEP;
			end
		end
	end

	assign fe_cmd = '{sample: cmd_sample, sample_ch: cmd_sample_ch,
		convert: cmd_convert, convert_ch: cmd_convert_ch,
		group: cfg.group};

	// Start bit mirrors a running sweep, but a trigger in the cycle of a halting write sets it with none running; a write of 1 does not start one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conversion_start_bit <= 1'h0;
		end else if (start_sweep) begin
			conversion_start_bit <= 1'h1;
		end else if (sw_halt || finish) begin
			conversion_start_bit <= 1'h0;
		end
	end

	// One pulse per whole sweep, not per input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sweep_done_irq <= 1'h0;
		end else begin
			sweep_done_irq <= finish & ~sw_halt;
		end
	end

	// Sticky done flag, write one to clear; a new finish wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sweep_done <= 1'h0;
		end else if (finish && !sw_halt) begin
			sweep_done <= 1'h1;
		end else if (wr_low && aw_addr == OFS_STAT && w_data[ST_DONE]) begin
			sweep_done <= 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= CFG_RST;
		end else if (wr_low && aw_addr == OFS_CTRL1) begin
			cfg.pin_count  <= {w_data[C1_CNT_HI], w_data[C1_CNT_LO]};
			cfg.trig_sel_a <= w_data[C1_TRGA];
			cfg.trig_sel_b <= w_data[C1_TRGB];
		end else if (wr_low && aw_addr == OFS_CTRL2) begin
			cfg.group <= {w_data[C2_GRP_HI], w_data[C2_GRP_LO]};
		end else if (wr_low && aw_addr == OFS_TRIG) begin
			cfg.mode2   <= w_data[TC_MODE2];
			cfg.mode3   <= w_data[TC_MODE3];
			cfg.in0_sel <= w_data[TC_SEL0];
			cfg.in1_sel <= w_data[TC_SEL1];
		end
	end

	// Write channel: address and data taken in either order
	assign s_axil_awready = ~aw_held & ~s_axil_bvalid;
	assign s_axil_wready  = ~w_held & ~s_axil_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'h0;
			aw_addr <= OFS_CTRL1;
		end else if (s_axil_awvalid && s_axil_awready) begin
			aw_held <= 1'h1;
			aw_addr <= s_axil_awaddr;
		end else if (wr_fire) begin
			aw_held <= 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'h0;
			w_data <= '0;
			w_strb <= 4'h0;
		end else if (s_axil_wvalid && s_axil_wready) begin
			w_held <= 1'h1;
			w_data <= s_axil_wdata;
			w_strb <= s_axil_wstrb;
		end else if (wr_fire) begin
			w_held <= 1'h0;
		end
	end

	assign wr_ok = (aw_addr == OFS_CTRL1) | (aw_addr == OFS_CTRL2)
		| (aw_addr == OFS_TRIG) | (aw_addr == OFS_STAT)
		| ((aw_addr & RES_MASK) == OFS_RES_BASE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_bvalid <= 1'h0;
			s_axil_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axil_bvalid <= 1'h1;
			s_axil_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axil_bready) begin
			s_axil_bvalid <= 1'h0;
		end
	end

	// Read channel: one wait cycle for the registered result store
	assign s_axil_arready = ~rd_pend & ~s_axil_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_pend <= 1'h0;
			rd_addr <= OFS_CTRL1;
		end else if (s_axil_arvalid && s_axil_arready) begin
			rd_pend <= 1'h1;
			rd_addr <= s_axil_araddr;
		end else begin
			rd_pend <= 1'h0;
		end
	end

	always_comb begin
		rd_word = '0;
		rd_ok   = 1'h1;
		if (rd_addr == OFS_CTRL1) begin
			rd_word[C1_CNT_LO] = cfg.pin_count[0];
			rd_word[C1_CNT_HI] = cfg.pin_count[1];
			rd_word[C1_START]  = conversion_start_bit;
			rd_word[C1_TRGA]   = cfg.trig_sel_a;
			rd_word[C1_TRGB]   = cfg.trig_sel_b;
		end else if (rd_addr == OFS_CTRL2) begin
			rd_word[C2_GRP_LO] = cfg.group[0];
			rd_word[C2_GRP_HI] = cfg.group[1];
		end else if (rd_addr == OFS_TRIG) begin
			// Bits above stay zero
			rd_word[TC_MODE2] = cfg.mode2;
			rd_word[TC_MODE3] = cfg.mode3;
			rd_word[TC_SEL0]  = cfg.in0_sel;
			rd_word[TC_SEL1]  = cfg.in1_sel;
		end else if (rd_addr == OFS_STAT) begin
			rd_word[ST_BUSY]  = (state != st_idle);
			rd_word[ST_WAIT]  = (state == st_wait1);
			rd_word[ST_EARLY] = early1;
			rd_word[ST_DONE]  = sweep_done;
		end else if ((rd_addr & RES_MASK) == OFS_RES_BASE) begin
			rd_word[RES_W-1:0] = mem_rdata;
		end else begin
			rd_ok = 1'h0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axil_rvalid <= 1'h0;
			s_axil_rdata  <= '0;
			s_axil_rresp  <= RESP_OKAY;
		end else if (rd_pend) begin
			s_axil_rvalid <= 1'h1;
			s_axil_rdata  <= rd_word;
			s_axil_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axil_rready) begin
			s_axil_rvalid <= 1'h0;
		end
	end
endmodule

// ---- adcdt_pkg.sv ----
// Package: constants, register map and carrier types of the sweep sequencer
package adcdt_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int RES_W  = 10;
	localparam int CH_W   = 3;
	localparam int NUM_CH = 8;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL1    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CTRL2    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TRIG     = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STAT     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_RES_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] RES_MASK     = 8'he0;
	localparam int                RES_IDX_LSB  = 2;

	// converter_ctrl_1 fields
	localparam int C1_CNT_LO = 0;
	localparam int C1_CNT_HI = 1;
	localparam int C1_START  = 2;
	localparam int C1_TRGA   = 3;
	localparam int C1_TRGB   = 4;
	// converter_ctrl_2 fields
	localparam int C2_GRP_LO = 0;
	localparam int C2_GRP_HI = 1;
	// trigger_control_reg fields, bits 7:4 unimplemented
	localparam int TC_MODE2  = 0;
	localparam int TC_MODE3  = 1;
	localparam int TC_SEL0   = 2;
	localparam int TC_SEL1   = 3;
	// converter_status fields
	localparam int ST_BUSY   = 0;
	localparam int ST_WAIT   = 1;
	localparam int ST_EARLY  = 2;
	localparam int ST_DONE   = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [CH_W-1:0]  CH_FIRST  = 3'h0;
	localparam logic [CH_W-1:0]  CH_SECOND = 3'h1;
	localparam logic [CH_W-1:0]  CH_STEP   = 3'h1;
	localparam logic [RES_W-1:0] RES_RST   = 10'h000;

	typedef enum logic [3:0] {
		st_idle  = 4'h1,
		st_conv0 = 4'h2,
		st_wait1 = 4'h4,
		st_convn = 4'h8
	} adcdt_state_t;

	typedef struct packed {
		logic [1:0] pin_count;
		logic       trig_sel_a;
		logic       trig_sel_b;
		logic [1:0] group;
		logic       mode2;
		logic       mode3;
		logic       in0_sel;
		logic       in1_sel;
	} adcdt_cfg_t;

	localparam adcdt_cfg_t CFG_RST = '0;

	// Commands to the analog sampling and conversion core
	typedef struct packed {
		logic            sample;
		logic [CH_W-1:0] sample_ch;
		logic            convert;
		logic [CH_W-1:0] convert_ch;
		logic [1:0]      group;
	} adcdt_fe_cmd_t;

	// Answer from the core: one pulse per finished conversion
	typedef struct packed {
		logic             done;
		logic [RES_W-1:0] data;
	} adcdt_fe_rsp_t;

endpackage

// ---- adcdt_trig_sync.sv ----
// Trigger pin synchroniser and falling edge detector
`timescale 1ns/1ns
module adcdt_trig_sync (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ext_trigger_n,
	output logic      trig_fall
);
	import adcdt_pkg::*;

	logic meta;
	logic level;
	logic prev;

	// Idle level of the pin is high, so no edge is seen out of reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta  <= 1'h1;
			level <= 1'h1;
			prev  <= 1'h1;
		end else begin
			meta  <= ext_trigger_n;
			level <= meta;
			prev  <= level;
		end
	end

	// Edges closer than one clock merge into one
	assign trig_fall = prev & ~level;
endmodule

// ---- adcdt_result_mem.sv ----
// Per-input result store with registered read port
`timescale 1ns/1ns
module adcdt_result_mem (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic                       we,
	input  wire logic [adcdt_pkg::CH_W-1:0] waddr,
	input  wire logic [adcdt_pkg::RES_W-1:0] wdata,
	input  wire logic [adcdt_pkg::CH_W-1:0] raddr,
	output logic [adcdt_pkg::RES_W-1:0]     rdata
);
	import adcdt_pkg::*;

	logic [RES_W-1:0] mem [NUM_CH];

	for (genvar i = 0; i < NUM_CH; i++) begin : g_entry
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				mem[i] <= RES_RST;
			end else if (we && (waddr == CH_W'(i))) begin
				mem[i] <= wdata;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= RES_RST;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ---- adcdt_seq_checker.sv ----
// Port-level assertions for the delayed trigger sweep sequencer
`timescale 1ns/1ns
module adcdt_seq_checker (
	input wire logic                     aclk,
	input wire logic                     aresetn,
	input wire logic                     s_axil_awready,
	input wire logic                     s_axil_wready,
	input wire logic [1:0]               s_axil_bresp,
	input wire logic                     s_axil_bvalid,
	input wire logic                     s_axil_bready,
	input wire logic                     s_axil_arvalid,
	input wire logic                     s_axil_arready,
	input wire logic [31:0]              s_axil_rdata,
	input wire logic                     s_axil_rvalid,
	input wire logic                     s_axil_rready,
	input wire adcdt_pkg::adcdt_fe_rsp_t fe_rsp,
	input wire adcdt_pkg::adcdt_fe_cmd_t fe_cmd,
	input wire logic                     sweep_done_irq
);
	import adcdt_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_irq_single: assert property (
		sweep_done_irq |=> !sweep_done_irq) else $error("irq too long");
	a_irq_after_done: assert property (
		sweep_done_irq |-> $past(fe_rsp.done)) else $error("irq without done");
	a_irq_last_odd: assert property (
		sweep_done_irq |-> fe_cmd.convert_ch[0]) else $error("sweep end ch");
	a_start_pair: assert property (
		fe_cmd.sample && fe_cmd.sample_ch == CH_FIRST
		|-> fe_cmd.convert && fe_cmd.convert_ch == CH_FIRST)
		else $error("input 0 start not paired");
	a_convert_order: assert property (
		fe_cmd.convert && fe_cmd.convert_ch != CH_FIRST
		|-> fe_cmd.convert_ch == $past(fe_cmd.convert_ch) + CH_STEP)
		else $error("channel order broken");
	a_b_hold: assert property (
		s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (
		s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
		else $error("read data dropped");
	a_rd_latency: assert property (
		s_axil_arvalid && s_axil_arready |=> !s_axil_arready ##1 s_axil_rvalid)
		else $error("read latency");
	a_wr_latency: assert property (
		$rose(s_axil_bvalid) |-> $past(!s_axil_awready && !s_axil_wready))
		else $error("write response early");
	c_irq: cover property (sweep_done_irq);
	c_early: cover property (fe_cmd.sample && !fe_cmd.convert);
	c_last7: cover property (fe_cmd.convert && fe_cmd.convert_ch == 3'h7);
endmodule

bind adcdt_seq_top adcdt_seq_checker chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axil_awready(s_axil_awready), .s_axil_wready(s_axil_wready),
	.s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
	.s_axil_bready(s_axil_bready), .s_axil_arvalid(s_axil_arvalid),
	.s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
	.s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
	.fe_rsp(fe_rsp), .fe_cmd(fe_cmd), .sweep_done_irq(sweep_done_irq));

// ---- adcdt_core_model.sv ----
// Far side: trigger source on the pin and a converter core
`timescale 1ns/1ns
module adcdt_core_model (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     fire,
	input  wire logic [7:0]               delay,
	input  wire adcdt_pkg::adcdt_fe_cmd_t fe_cmd,
	output adcdt_pkg::adcdt_fe_rsp_t      fe_rsp,
	output logic                          ext_trigger_n
);
	import adcdt_pkg::*;
	logic [1:0] low_cnt;
	logic [7:0] cnt;
	logic [9:0] val;
	// Pin held low two cycles, edges never closer than one clock
	always_ff @(posedge aclk) begin
		if (!aresetn)
			low_cnt <= 2'h0;
		else if (fire)
			low_cnt <= 2'h2;
		else if (low_cnt != 2'h0)
			low_cnt <= low_cnt - 2'h1;
	end
	// Pull-up brings the pin high once released
	assign ext_trigger_n = (low_cnt == 2'h0);
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt <= 8'h00;
		else if (fe_cmd.convert) begin
			cnt <= delay;
			val <= {fe_cmd.group, fe_cmd.convert_ch, 5'h0b};
		end else if (cnt != 8'h00)
			cnt <= cnt - 8'h01;
	end
	// Data is scrambled outside the done pulse
	assign fe_rsp = '{done: (cnt == 8'h01),
		data: (cnt == 8'h01) ? val : ~val};
endmodule

// ---- adc_delayed_trigger_sweep_seq_test.sv ----
// Self-checking bench for the delayed trigger sweep sequencer
`timescale 1ns/1ns
module adc_delayed_trigger_sweep_seq_test;
	import adcdt_pkg::*;
	logic aclk = 0, aresetn = 0, fire = 0, t0 = 0, t1 = 0;
	logic [7:0] awaddr = 0, araddr = 0, delay = 8'h04;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq, pin_n;
	logic [1:0] bresp, rresp;
	logic [3:0] wstrb = 4'hf;
	// Late ready: answer stands before the master takes it
	logic late = 0;
	adcdt_fe_cmd_t fe_cmd;
	adcdt_fe_rsp_t fe_rsp;
	int fails = 0, checks = 0, cyc = 0, n_conv = 0, n_irq = 0, n_early = 0;
	always #20 aclk = ~aclk;
	adcdt_seq_top dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axil_awaddr(awaddr), .s_axil_awprot(3'h0), .s_axil_awvalid(awvalid),
		.s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
		.s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
		.s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
		.s_axil_arprot(3'h0), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
		.s_axil_rready(rready), .ext_trigger_n(pin_n), .timer0_underflow(t0),
		.timer1_underflow(t1), .fe_rsp(fe_rsp), .fe_cmd(fe_cmd),
		.sweep_done_irq(irq));
	adcdt_core_model core_u (.aclk(aclk), .aresetn(aresetn), .fire(fire),
		.delay(delay), .fe_cmd(fe_cmd), .fe_rsp(fe_rsp), .ext_trigger_n(pin_n));
	// Counted at the falling edge so outputs are settled
	always @(negedge aclk) begin
		if (aresetn) begin
			if (fe_cmd.convert === 1'b1) n_conv++;
			if (irq === 1'b1) n_irq++;
			if (fe_cmd.sample === 1'b1 && fe_cmd.sample_ch === CH_SECOND &&
				fe_cmd.convert === 1'b0) n_early++;
		end
	end
	task automatic conclude;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Handshake seen at the falling edge holds until the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bv, bh;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= !late;
		do begin
			@(negedge aclk);
			ah = awvalid && awready; wh = wvalid && wready;
			bv = bvalid; bh = bv && bready; r = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 0;
			if (wh) wvalid <= 0;
			if (bv && !bh) bready <= 1;
		end while (bh !== 1'b1);
		bready <= 0;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ah, rv, rh;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= !late;
		do begin
			@(negedge aclk);
			ah = arvalid && arready; rv = rvalid; rh = rv && rready;
			d = rdata; r = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 0;
			if (rv && !rh) rready <= 1;
		end while (rh !== 1'b1);
		rready <= 0;
		chk(n, e, d);
		chk("resp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic trig;
		@(posedge aclk); fire <= 1;
		@(posedge aclk); fire <= 0;
	endtask
	task automatic upto(ref int v, input int t);
		while (v < t) @(posedge aclk);
	endtask
	task automatic regs_test;
		logic [1:0] r;
		rchk("ctrl1", OFS_CTRL1, 32'h0, RESP_OKAY);
		wstrb <= 4'h0;
		wr(OFS_CTRL2, 32'h3, r);
		wstrb <= 4'hf;
		rchk("strb_off", OFS_CTRL2, 32'h0, RESP_OKAY);
		late = 1;
		rchk("unmapped", 8'h10, 32'h0, RESP_SLVERR);
		wr(8'h10, 32'h1, r);
		late = 0;
		chk("wr_unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(OFS_TRIG, 32'hff, r);
		rchk("trig_upper", OFS_TRIG, 32'h0f, RESP_OKAY);
		wr(OFS_TRIG, 32'h03, r);
	endtask
	// Start bit is never written as 1 in delayed mode 1
	task automatic sweep(input logic [1:0] pc, input logic early);
		int bc, bi, be, i;
		logic [1:0] r;
		wr(OFS_CTRL2, {30'h0, pc}, r);
		wr(OFS_CTRL1, 32'h10 | pc, r);
		bc = n_conv; bi = n_irq; be = n_early;
		delay <= early ? 8'h14 : 8'h0a;
		trig();
		upto(n_conv, bc + 1);
		if (early) begin
			trig();
			upto(n_irq, bi + 1);
			chk("early_sample", be + 1, n_early);
			rchk("stat_early", OFS_STAT, 32'h0c, RESP_OKAY);
		end else begin
			repeat (12) @(posedge aclk);
			chk("ch1_held", bc + 1, n_conv);
			rchk("stat_wait", OFS_STAT,
				(pc == 2'h0) ? 32'h03 : 32'h0b, RESP_OKAY);
			rchk("start_run", OFS_CTRL1, 32'h14 | pc, RESP_OKAY);
			trig();
			upto(n_conv, bc + 2);
			trig();
			upto(n_irq, bi + 1);
		end
		repeat (20) @(posedge aclk);
		chk("irq_count", bi + 1, n_irq);
		chk("conv_count", bc + 2 * pc + 2, n_conv);
		rchk("start_clr", OFS_CTRL1, 32'h10 | pc, RESP_OKAY);
		for (i = 0; i <= 2 * pc + 1; i++)
			rchk("result", OFS_RES_BASE + 8'(4 * i),
				{22'h0, pc, 3'(i), 5'h0b}, RESP_OKAY);
	endtask
	task automatic halt_test;
		int bi;
		logic [1:0] r;
		wr(OFS_CTRL1, 32'h10, r);
		bi = n_irq;
		delay <= 8'h28;
		trig();
		upto(n_conv, n_conv + 1);
		wr(OFS_CTRL1, 32'h10, r);
		repeat (60) @(posedge aclk);
		chk("halt_irq", bi, n_irq);
		rchk("halt_stat", OFS_STAT, 32'h08, RESP_OKAY);
		wr(OFS_STAT, 32'h08, r);
		rchk("stat_clear", OFS_STAT, 32'h0, RESP_OKAY);
	endtask
	task automatic mode0_test;
		int bi;
		logic [1:0] r;
		wr(OFS_TRIG, 32'h0f, r);
		wr(OFS_CTRL1, 32'h0, r);
		bi = n_irq;
		delay <= 8'h04;
		@(posedge aclk); t0 <= 1;
		@(posedge aclk); t0 <= 0;
		repeat (12) @(posedge aclk);
		t1 <= 1;
		@(posedge aclk); t1 <= 0;
		repeat (20) @(posedge aclk);
		chk("mode0_irq", bi + 1, n_irq);
	endtask
	initial begin
		int p;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		regs_test();
		for (p = 0; p < 4; p++)
			sweep(2'(p), p[0]);
		halt_test();
		mode0_test();
		conclude();
	end
endmodule
